// File: nasc_pkg.sv
package nasc_pkg;

    // --------------------------------------------------------------
    // Register indices (one 16-bit register each)
    // --------------------------------------------------------------
    localparam logic [15:0] NASC_CFG_HI = 16'h4011;
    localparam logic [15:0] NASC_CFG_LO = 16'h4012;
    localparam logic [15:0] NASC_PCODE_HI = 16'h4014;
    localparam logic [15:0] NASC_PCODE_LO = 16'h4015;
    localparam logic [15:0] NASC_PNAME_FIRST = 16'h4016;
    localparam logic [15:0] NASC_PNAME_LAST = 16'h4035;
    localparam logic [15:0] NASC_IN_IMG = 16'h4036;
    localparam logic [15:0] NASC_OUT_IMG = 16'h4037;
    localparam logic [15:0] NASC_ALIAS_STORED = 16'h4100;
    localparam logic [15:0] NASC_ALIAS_ACTIVE = 16'h4101;
    localparam logic [15:0] NASC_ALIAS_CHAIN = 16'h4103;
    localparam logic [15:0] NASC_ID_STORED = 16'h4104;

    // --------------------------------------------------------------
    // Reset values and sizes
    // --------------------------------------------------------------
    localparam logic [31:0] NASC_CFG_RESET = 32'h0000_0008;
    localparam logic [15:0] NASC_IN_IMG_SIZE = 16'h0100;
    localparam logic [15:0] NASC_OUT_IMG_SIZE = 16'h0100;
    localparam int NASC_PNAME_BYTES = 32;
    localparam logic [3:0] NASC_MAX_DIGIT = 4'h9;

    // --------------------------------------------------------------
    // Field positions of the configuration word
    // --------------------------------------------------------------
    localparam int NASC_ALIAS_SEL_LSB = 0;
    localparam int NASC_ALIAS_FMT_BIT = 3;
    localparam int NASC_ID_SEL_LSB = 4;
    localparam int NASC_ID_FMT_BIT = 7;

    typedef enum logic [2:0] {
        NASC_ALIAS_FROM_REG = 3'b000,
        NASC_ALIAS_FROM_CHAIN = 3'b001,
        NASC_ALIAS_FROM_BUS = 3'b010,
        NASC_ALIAS_FROM_SWITCH = 3'b011
    } nasc_alias_src_e;

    typedef enum logic [2:0] {
        NASC_ID_FROM_REG = 3'b000,
        NASC_ID_FROM_CHAIN = 3'b001,
        NASC_ID_INVALID = 3'b010,
        NASC_ID_FROM_SWITCH = 3'b011
    } nasc_id_src_e;

    typedef struct packed {
        logic [23:0] unused;
        logic device_id_switch_format;
        logic [2:0] device_id_source_select;
        logic alias_switch_format;
        logic [2:0] alias_source_select;
    } nasc_cfg_s;

    typedef struct packed {
        logic [15:0] value;
        logic valid;
    } nasc_addr_s;

endpackage : nasc_pkg

// File: nasc_switch_decode.sv
`timescale 1ns/10ps
`default_nettype none
module nasc_switch_decode
    import nasc_pkg::*;
(
    input wire logic bcd_format, // 1 = BCD, 0 = binary
    input wire logic [7:0] raw, // Synchronised switch value
    output nasc_addr_s decoded // Value and validity
);
    // ----------------------------------------------------------
    // Digit checks
    // ----------------------------------------------------------
    wire logic tens_ok = raw[7:4] <= NASC_MAX_DIGIT;
    wire logic units_ok = raw[3:0] <= NASC_MAX_DIGIT;
    wire logic [15:0] bcd_value =
        16'(raw[7:4]) * 16'h000A + 16'(raw[3:0]);
    wire logic bin_ok = raw <= {4'h0, NASC_MAX_DIGIT};

    assign decoded.value = bcd_format ? bcd_value : {8'h00, raw};
    assign decoded.valid = bcd_format ? tens_ok && units_ok : bin_ok;
endmodule : nasc_switch_decode
`default_nettype wire

// File: nasc_regbank.sv
`timescale 1ns/10ps
`default_nettype none
module nasc_regbank
    import nasc_pkg::*;
#(
    parameter logic [31:0] PRODUCT_CODE_INIT = 32'h0000_0001, // arbitrary
    parameter logic [255:0] PRODUCT_NAME_INIT = 256'h4E4F4445, // arbitrary
    parameter logic [15:0] OUT_IMG_SIZE = NASC_OUT_IMG_SIZE
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [15:0] reg_addr, // Register index
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data
    output logic reg_rvalid, // Read data valid
    input wire logic apply_cfg, // Reload active values
    input wire logic [15:0] bus_alias, // Alias from fieldbus engine
    input wire logic [7:0] alias_switch_pin, // Rotary switch, alias
    input wire logic [7:0] id_switch_pin, // Rotary switch, device ID
    input wire logic [15:0] shift_chain_input, // Alias from shift chain
    output logic [15:0] active_alias, // Alias in use
    output logic [15:0] active_device_id, // Device ID in use
    output logic [31:0] product_code_out, // Identity entry four
    output nasc_cfg_s cfg_out // Configuration word
);
    // ----------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------
    logic [7:0] asw_meta_reg;
    logic [7:0] asw_reg;
    logic [7:0] isw_meta_reg;
    logic [7:0] isw_reg;
    logic [15:0] chain_meta_reg;
    logic [15:0] chain_reg;

    // Switches are quasi-static, so a plain two-stage bus sync is enough
    always_ff @(posedge clk) begin
        asw_meta_reg <= alias_switch_pin;
        asw_reg <= asw_meta_reg;
        isw_meta_reg <= id_switch_pin;
        isw_reg <= isw_meta_reg;
        chain_meta_reg <= shift_chain_input;
        chain_reg <= chain_meta_reg;
    end

    // ----------------------------------------------------------
    // Storage
    // ----------------------------------------------------------
    nasc_cfg_s cfg_reg;
    logic [31:0] pcode_reg;
    logic [7:0] pname_reg [NASC_PNAME_BYTES];
    logic [15:0] alias_stored_reg;
    logic [15:0] id_stored_reg;
    logic [15:0] alias_active_reg;
    logic [15:0] alias_active_next;
    logic [15:0] id_active_reg;
    logic [15:0] id_active_next;
    logic [15:0] rdata_reg;
    logic rvalid_reg;

    // ----------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        hit = (a == r);
    endfunction : hit

    wire logic in_pname = (reg_addr >= NASC_PNAME_FIRST) &&
        (reg_addr <= NASC_PNAME_LAST);
    wire logic [4:0] pname_idx = 5'(reg_addr - NASC_PNAME_FIRST);
    wire logic wr_cfg_hi = reg_wr && hit(reg_addr, NASC_CFG_HI);
    wire logic wr_cfg_lo = reg_wr && hit(reg_addr, NASC_CFG_LO);
    wire logic wr_pc_hi = reg_wr && hit(reg_addr, NASC_PCODE_HI);
    wire logic wr_pc_lo = reg_wr && hit(reg_addr, NASC_PCODE_LO);
    wire logic wr_pname = reg_wr && in_pname;
    wire logic wr_alias = reg_wr && hit(reg_addr, NASC_ALIAS_STORED);
    wire logic wr_id = reg_wr && hit(reg_addr, NASC_ID_STORED);

    // ----------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_reg <= NASC_CFG_RESET;
            pcode_reg <= PRODUCT_CODE_INIT;
            alias_stored_reg <= 16'h0000;
            id_stored_reg <= 16'h0000;
        end else begin
            if (wr_cfg_hi) begin
                cfg_reg[31:16] <= reg_wdata;
            end
            if (wr_cfg_lo) begin
                cfg_reg[15:0] <= reg_wdata;
            end
            if (wr_pc_hi) begin
                pcode_reg[31:16] <= reg_wdata;
            end
            if (wr_pc_lo) begin
                pcode_reg[15:0] <= reg_wdata;
            end
            if (wr_alias) begin
                alias_stored_reg <= reg_wdata;
            end
            if (wr_id) begin
                id_stored_reg <= reg_wdata;
            end
        end
    end

    // One byte per register, low lane; first register holds first char
    genvar gi;
    generate
        for (gi = 0; gi < NASC_PNAME_BYTES; gi++) begin : g_pname
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    pname_reg[gi] <= PRODUCT_NAME_INIT[8*gi +: 8];
                end else if (wr_pname && pname_idx == 5'(gi)) begin
                    pname_reg[gi] <= reg_wdata[7:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------
    nasc_addr_s alias_sw;
    nasc_addr_s id_sw;

    nasc_switch_decode u_alias_sw (
        .bcd_format(cfg_reg.alias_switch_format),
        .raw(asw_reg),
        .decoded(alias_sw)
    );

    nasc_switch_decode u_id_sw (
        .bcd_format(cfg_reg.device_id_switch_format),
        .raw(isw_reg),
        .decoded(id_sw)
    );

    // Writing the config word counts as applying it
    wire logic do_apply = apply_cfg || wr_cfg_lo || wr_cfg_hi;
    wire nasc_alias_src_e alias_src =
        nasc_alias_src_e'(cfg_reg.alias_source_select);
    wire nasc_id_src_e id_src = nasc_id_src_e'(cfg_reg.device_id_source_select);

    always_comb begin
        alias_active_next = alias_active_reg;
        unique case (alias_src)
            NASC_ALIAS_FROM_REG: alias_active_next = alias_stored_reg;
            NASC_ALIAS_FROM_BUS: alias_active_next = bus_alias;
            NASC_ALIAS_FROM_SWITCH: begin
                if (alias_sw.valid) begin
                    alias_active_next = alias_sw.value;
                end
            end
            NASC_ALIAS_FROM_CHAIN: alias_active_next = alias_active_reg;
            default: alias_active_next = alias_active_reg;
        endcase
    end

    always_comb begin
        id_active_next = id_active_reg;
        unique case (id_src)
            NASC_ID_FROM_REG: id_active_next = id_stored_reg;
            NASC_ID_FROM_SWITCH: begin
                if (id_sw.valid) begin
                    id_active_next = id_sw.value;
                end
            end
            NASC_ID_FROM_CHAIN: id_active_next = id_active_reg;
            NASC_ID_INVALID: id_active_next = id_active_reg;
            default: id_active_next = id_active_reg;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alias_active_reg <= 16'h0000;
            id_active_reg <= 16'h0000;
        end else if (do_apply) begin
            alias_active_reg <= alias_active_next;
            id_active_reg <= id_active_next;
        end
    end

    // ----------------------------------------------------------
    // Read path
    // ----------------------------------------------------------
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        if (in_pname) begin
            rd_mux = {8'h00, pname_reg[pname_idx]};
        end else begin
            unique case (reg_addr)
                NASC_CFG_HI: rd_mux = cfg_reg[31:16];
                NASC_CFG_LO: rd_mux = cfg_reg[15:0];
                NASC_PCODE_HI: rd_mux = pcode_reg[31:16];
                NASC_PCODE_LO: rd_mux = pcode_reg[15:0];
                NASC_IN_IMG: rd_mux = NASC_IN_IMG_SIZE;
                NASC_OUT_IMG: rd_mux = OUT_IMG_SIZE;
                NASC_ALIAS_STORED: rd_mux = alias_stored_reg;
                NASC_ALIAS_ACTIVE: rd_mux = alias_active_reg;
                NASC_ALIAS_CHAIN: rd_mux = chain_reg;
                NASC_ID_STORED: rd_mux = id_stored_reg;
                default: rd_mux = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
            if (reg_rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign active_alias = alias_active_reg;
    assign active_device_id = id_active_reg;
    assign product_code_out = pcode_reg;
    assign cfg_out = cfg_reg;

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CFG_RESET: assert property (
        $rose(rst_n) |-> cfg_reg == NASC_CFG_RESET)
        else $error("config word not at reset value");

    AST_ALIAS_REG: assert property (
        do_apply && alias_src == NASC_ALIAS_FROM_REG
        |=> active_alias == $past(alias_stored_reg))
        else $error("stored alias not adopted");

    AST_ALIAS_BUS: assert property (
        do_apply && alias_src == NASC_ALIAS_FROM_BUS
        |=> active_alias == $past(bus_alias))
        else $error("fieldbus alias not adopted");

    AST_ALIAS_CHAIN_HOLD: assert property (
        do_apply && alias_src == NASC_ALIAS_FROM_CHAIN
        |=> $stable(active_alias))
        else $error("reserved select changed alias");

    AST_SW_INVALID_HOLD: assert property (
        do_apply && alias_src == NASC_ALIAS_FROM_SWITCH && !alias_sw.valid
        |=> $stable(active_alias))
        else $error("invalid switch value adopted");

    AST_SW_BIN: assert property (
        do_apply && alias_src == NASC_ALIAS_FROM_SWITCH &&
        !cfg_reg.alias_switch_format && asw_reg <= 8'h09
        |=> active_alias == {8'h00, $past(asw_reg)})
        else $error("binary switch alias wrong");

    AST_ID_REG: assert property (
        do_apply && id_src == NASC_ID_FROM_REG
        |=> active_device_id == $past(id_stored_reg))
        else $error("stored device ID not adopted");

    AST_ID_INVALID: assert property (
        do_apply && id_src == NASC_ID_INVALID |=> $stable(active_device_id))
        else $error("invalid ID select changed ID");

    AST_IMG_READ: assert property (
        reg_rd && reg_addr == NASC_IN_IMG
        |=> reg_rvalid && reg_rdata == NASC_IN_IMG_SIZE)
        else $error("input image size read wrong");

    AST_PCODE_HI: assert property (
        wr_pc_hi |=> product_code_out[31:16] == $past(reg_wdata))
        else $error("product code high word not written");

    AST_NO_APPLY_HOLD: assert property (
        !do_apply |=> $stable(active_alias))
        else $error("active alias moved without apply");

    // Reference for BCD switches, built as 8x + 2x + y
    wire logic [15:0] asw_bcd_ref = 16'({asw_reg[7:4], 3'b000}) +
        16'({asw_reg[7:4], 1'b0}) + 16'(asw_reg[3:0]);

    AST_ALIAS_SW_BCD: assert property (
        do_apply && alias_src == NASC_ALIAS_FROM_SWITCH &&
        cfg_reg.alias_switch_format &&
        asw_reg[7:4] <= 4'h9 && asw_reg[3:0] <= 4'h9
        |=> active_alias == $past(asw_bcd_ref))
        else $error("BCD switch alias wrong");

    AST_ID_SW_HOLD: assert property (
        do_apply && id_src == NASC_ID_FROM_SWITCH && !id_sw.valid
        |=> $stable(active_device_id))
        else $error("invalid ID switch value adopted");

    AST_ID_CHAIN_HOLD: assert property (
        do_apply && id_src == NASC_ID_FROM_CHAIN
        |=> $stable(active_device_id))
        else $error("reserved ID select changed ID");

    AST_CHAIN_READ: assert property (
        reg_rd && reg_addr == NASC_ALIAS_CHAIN
        |=> reg_rdata == $past(chain_reg))
        else $error("shift chain alias read wrong");

    AST_OUT_IMG_READ: assert property (
        reg_rd && reg_addr == NASC_OUT_IMG
        |=> reg_rvalid && reg_rdata == OUT_IMG_SIZE)
        else $error("output image size read wrong");

    AST_PCODE_LO: assert property (
        wr_pc_lo |=> product_code_out[15:0] == $past(reg_wdata))
        else $error("product code low word not written");

    COV_ALIAS_SWITCH: cover property (
        do_apply && alias_src == NASC_ALIAS_FROM_SWITCH && alias_sw.valid);
    COV_ALIAS_BCD: cover property (
        do_apply && cfg_reg.alias_switch_format && alias_sw.valid);
    COV_ID_SWITCH: cover property (
        do_apply && id_src == NASC_ID_FROM_SWITCH);
    COV_PNAME_WRITE: cover property (wr_pname ##1 reg_rd && in_pname);

endmodule : nasc_regbank
`default_nettype wire

// File: nasc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module nasc_host_model (
    input wire logic clk, // Bench clock
    output logic [15:0] reg_addr, // Register index
    output logic [15:0] reg_wdata, // Write data
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    input wire logic [15:0] reg_rdata, // Read data
    input wire logic reg_rvalid // Read data valid
);
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Data inverted once released, so a stale value never passes
    task automatic write_reg(input logic [15:0] addr,
                             input logic [15:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~data;
    endtask : write_reg

    task automatic read_reg(input logic [15:0] addr,
                            output logic [15:0] data, output logic ok);
        ok = 1'b0;
        data = 16'h0000;
        @(posedge clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                data = reg_rdata;
            end
        end
    endtask : read_reg
endmodule : nasc_host_model
`default_nettype wire

// File: node_address_source_config_bench.sv
`timescale 1ns/10ps
`default_nettype none
module node_address_source_config_bench;
    import nasc_pkg::*;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } nasc_row_s;

    logic clk;
    logic rst_n;
    logic apply_cfg;
    logic [15:0] bus_alias;
    logic [7:0] alias_switch_pin;
    logic [7:0] id_switch_pin;
    logic [15:0] shift_chain_input;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic [15:0] active_alias;
    logic [15:0] active_device_id;
    logic [31:0] product_code_out;
    nasc_cfg_s cfg_out;
    int mismatches = 0;
    int check_count = 0;

    // ------------------------------------------------------------
    // Register cases: optional write, then read back
    // ------------------------------------------------------------
    nasc_row_s rows [13] = '{
        '{1'b0, NASC_CFG_LO, 16'h0000, 16'h0008},
        '{1'b0, NASC_CFG_HI, 16'h0000, 16'h0000},
        '{1'b0, NASC_IN_IMG, 16'h0000, 16'h0100},
        '{1'b0, NASC_OUT_IMG, 16'h0000, 16'h0100},
        '{1'b1, NASC_IN_IMG, 16'h1234, 16'h0100},
        '{1'b1, NASC_OUT_IMG, 16'h00FF, 16'h0100},
        '{1'b1, NASC_ALIAS_STORED, 16'hA5C3, 16'hA5C3},
        '{1'b1, NASC_ID_STORED, 16'hFFFF, 16'hFFFF},
        '{1'b1, NASC_PCODE_HI, 16'hBEEF, 16'hBEEF},
        '{1'b1, NASC_PCODE_LO, 16'h1234, 16'h1234},
        '{1'b1, NASC_PNAME_LAST, 16'h3C7A, 16'h007A},
        '{1'b1, 16'h4013, 16'h5555, 16'h0000},
        '{1'b1, NASC_ALIAS_ACTIVE, 16'h7777, 16'h0000}
    };

    nasc_regbank u_dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .apply_cfg(apply_cfg), .bus_alias(bus_alias),
        .alias_switch_pin(alias_switch_pin), .id_switch_pin(id_switch_pin),
        .shift_chain_input(shift_chain_input), .active_alias(active_alias),
        .active_device_id(active_device_id),
        .product_code_out(product_code_out), .cfg_out(cfg_out)
    );

    nasc_host_model u_host (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic summarize;
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_rd

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_out

    // Missing answer turns into unknown data, which never matches
    task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        u_host.read_reg(addr, d, ok);
        if (ok !== 1'b1) begin
            d = 16'hxxxx;
        end
        chk_rd(d, exp);
    endtask : rd

    // Config write applies the old word, so a second apply follows
    task automatic apply_check(input logic [15:0] cfg,
                               input logic [15:0] bus,
                               input logic [7:0] asw, input logic [7:0] isw,
                               input logic [15:0] ea,
                               input logic [15:0] eid);
        @(posedge clk);
        bus_alias <= bus;
        alias_switch_pin <= asw;
        id_switch_pin <= isw;
        u_host.write_reg(NASC_CFG_LO, cfg);
        @(posedge clk);
        apply_cfg <= 1'b1;
        @(posedge clk);
        apply_cfg <= 1'b0;
        @(posedge clk);
        chk_out({16'h0000, active_alias}, {16'h0000, ea});
        chk_out({16'h0000, active_device_id}, {16'h0000, eid});
        chk_out({24'h000000, cfg_out[7:0]}, {24'h000000, cfg[7:0]});
        rd(NASC_ALIAS_ACTIVE, ea);
    endtask : apply_check

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        apply_cfg = 1'b0;
        bus_alias = 16'h0000;
        alias_switch_pin = 8'h00;
        id_switch_pin = 8'h00;
        shift_chain_input = 16'hC0DE;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                u_host.write_reg(rows[i].addr, rows[i].wdata);
            end
            rd(rows[i].addr, rows[i].exp);
        end
        chk_out(product_code_out, 32'hBEEF1234);
        rd(NASC_ALIAS_CHAIN, 16'hC0DE);
        shift_chain_input <= 16'h3A5C;
        repeat (2) @(posedge clk);
        rd(NASC_ALIAS_CHAIN, 16'h3A5C);
        // ------------------------------------------------------------
        // Source selection, switch formats and held values
        // ------------------------------------------------------------
        apply_check(16'h0000, 16'h1357, 8'h07, 8'h05,
                    16'hA5C3, 16'hFFFF);
        apply_check(16'h0002, 16'h1357, 8'h07, 8'h05,
                    16'h1357, 16'hFFFF);
        apply_check(16'h0033, 16'h1357, 8'h07, 8'h05,
                    16'h0007, 16'h0005);
        apply_check(16'h0033, 16'h1357, 8'h0C, 8'h0A,
                    16'h0007, 16'h0005);
        apply_check(16'h00BB, 16'h1357, 8'h42, 8'h99,
                    16'h002A, 16'h0063);
        apply_check(16'h0021, 16'h2468, 8'h42, 8'h99,
                    16'h002A, 16'h0063);
        apply_check(16'h0012, 16'h2468, 8'h42, 8'h99,
                    16'h2468, 16'h0063);
        apply_check(16'h0000, 16'h2468, 8'h42, 8'h99,
                    16'hA5C3, 16'hFFFF);
        // ------------------------------------------------------------
        // Reset in mid-run restores the defaults
        // ------------------------------------------------------------
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_out(cfg_out, NASC_CFG_RESET);
        chk_out(product_code_out, 32'h0000_0001);
        rd(NASC_CFG_LO, 16'h0008);
        summarize();
    end
endmodule : node_address_source_config_bench
`default_nettype wire
